// >>> logic/adps_bank.v
// one port bank: analog select, direction and read gating
`include "adps_consts.vh"
module adps_bank #(
  parameter [15:0] SEL_MASK = 16'hFFFF
) (
  input wire clk_sys, // system clock
  input wire rst, // synchronous reset, active high
  input wire sel_we, // write strobe for analog select
  input wire dir_we, // write strobe for direction
  input wire [15:0] wdata, // write data
  input wire [1:0] wstrb, // byte enables, low two lanes
  input wire [15:0] pin_in, // pin levels from the pads
  output reg [15:0] analog_select, // analog select register
  output reg [15:0] direction, // direction register, 1 = input
  output wire [15:0] pin_level, // gated pin level readback
  output wire [15:0] analog_mode, // per pin analog mode
  output wire [15:0] output_en // per pin digital driver enable
);
  wire [15:0] lane_mask;

  assign lane_mask = {{8{wstrb[1]}}, {8{wstrb[0]}}};

  // ==========================================================
  // select register: absent bits held at zero, never written
  always @(posedge clk_sys) begin
    if (rst) begin
      analog_select <= `ADPS_SEL_RESET & SEL_MASK;
    end else if (sel_we) begin
      analog_select <= ((wdata & lane_mask) |
        (analog_select & ~lane_mask)) & SEL_MASK;
    end
  end

  // direction register, inputs after reset
  always @(posedge clk_sys) begin
    if (rst) begin
      direction <= `ADPS_DIR_RESET;
    end else if (dir_we) begin
      direction <= (wdata & lane_mask) | (direction & ~lane_mask);
    end
  end

  // analog pins block the digital read path and read low
  assign analog_mode = analog_select;
  assign pin_level = pin_in & ~analog_select;
  // driver only for a digital pin set as output
  assign output_en = ~direction & ~analog_select;
endmodule // adps_bank

// >>> logic/adps_consts.vh
// offsets, masks, reset values for the analog/digital pin select block
`ifndef ADPS_CONSTS_VH
`define ADPS_CONSTS_VH
// ==========================================================
// register byte addresses
`define ADPS_OFS_BANK_A 8'h00
`define ADPS_OFS_BANK_B 8'h04
`define ADPS_OFS_BANK_C 8'h08
`define ADPS_OFS_BANK_D 8'h0C
`define ADPS_OFS_BANK_E 8'h10
`define ADPS_OFS_BANK_F 8'h14
`define ADPS_OFS_DIR_A 8'h20
`define ADPS_OFS_DIR_B 8'h24
`define ADPS_OFS_DIR_C 8'h28
`define ADPS_OFS_DIR_D 8'h2C
`define ADPS_OFS_DIR_E 8'h30
`define ADPS_OFS_DIR_F 8'h34
`define ADPS_OFS_LVL_A 8'h40
`define ADPS_OFS_LVL_B 8'h44
`define ADPS_OFS_LVL_C 8'h48
`define ADPS_OFS_LVL_D 8'h4C
`define ADPS_OFS_LVL_E 8'h50
`define ADPS_OFS_LVL_F 8'h54
// ==========================================================
// implemented analog-select bits, full and small pin count variants
`define ADPS_MASK_A 16'h06C0
`define ADPS_MASK_B 16'hFFFF
`define ADPS_MASK_C 16'h6010
`define ADPS_MASK_C_SMALL 16'h6000
`define ADPS_MASK_D 16'h00C0
`define ADPS_MASK_E 16'h0200
`define ADPS_MASK_F 16'h0001
`define ADPS_MASK_NONE 16'h0000
// ==========================================================
// reset values
`define ADPS_SEL_RESET 16'hFFFF
`define ADPS_DIR_RESET 16'hFFFF
// axi response codes
`define ADPS_RESP_OKAY 2'b00
`define ADPS_RESP_SLVERR 2'b10
`endif

// >>> logic/adps_top.v
// analog/digital pin select block with an axi4-lite slave
//
// How it works
// - select 1 gives analog, read path blocked
// - select 0 gives digital, normal reads
// - implemented select bits reset to one
// - absent bits ignore writes, read zero
// - bank b implements all sixteen bits
// - bank a implements bits 10,9,7,6
// - bank c implements bits 14,13,4
// - bank d implements bits 7,6
// - bank e bit 9, bank f bit 0
// - small variant drops banks a,e, c4
// - analog pins read zero in level register
// - direction one is input; reset inputs
//
// register map, byte addresses on the bus:
//   0x00 to 0x14  analog select, banks a to f, four apart
//   0x20 to 0x34  direction, banks a to f, 1 = input
//   0x40 to 0x54  gated pin level, read only, writes ignored
//   anything else answers slverr and reads as zero
// only the low half of each word and byte lanes 0 and 1 are used;
// the upper half always reads zero
// bank a sits on pin_in[15:0], bank f on pin_in[95:80]
// pad levels are taken as already synchronous to clk_sys: a pad
// that can change freely needs a synchroniser in front, left out
// here to keep the level read one cycle long
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
`include "adps_consts.vh"
module adps_top #(
  parameter SMALL_PIN_COUNT = 0 // 1 selects the reduced variant
) (
  input wire clk_sys, // system clock, 100 MHz
  input wire rst, // synchronous reset, active high
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte enables
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [95:0] pin_in, // pad levels, banks f..a
  output wire [95:0] analog_mode, // analog mode per pin
  output wire [95:0] output_en // digital driver enable per pin
);
  // ==========================================================
  // variant masks
  localparam [15:0] MASK_A = SMALL_PIN_COUNT ?
    `ADPS_MASK_NONE : `ADPS_MASK_A;
  localparam [15:0] MASK_B = `ADPS_MASK_B;
  localparam [15:0] MASK_C = SMALL_PIN_COUNT ?
    `ADPS_MASK_C_SMALL : `ADPS_MASK_C;
  localparam [15:0] MASK_D = `ADPS_MASK_D;
  localparam [15:0] MASK_E = SMALL_PIN_COUNT ?
    `ADPS_MASK_NONE : `ADPS_MASK_E;
  localparam [15:0] MASK_F = `ADPS_MASK_F;

  // ==========================================================
  // write channel capture
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire wr_fire;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;

  // each channel taken once; held until the response is sent
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;

  always @(posedge clk_sys) begin
    if (rst) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // write fires as soon as both halves are present, this edge or held
  wire aw_have = aw_held | (s_axi_awvalid & s_axi_awready);
  wire w_have = w_held | (s_axi_wvalid & s_axi_wready);
  assign wr_fire = aw_have & w_have;
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;

  // ==========================================================
  // write decode
  // low two address bits ignored: every register is one word
  reg [5:0] sel_we;
  reg [5:0] dir_we;
  reg wr_hit;

  always @* begin
    sel_we = 6'h00;
    dir_we = 6'h00;
    wr_hit = 1'b1;
    case ({wr_addr[7:2], 2'b00})
      `ADPS_OFS_BANK_A: sel_we[0] = wr_fire;
      `ADPS_OFS_BANK_B: sel_we[1] = wr_fire;
      `ADPS_OFS_BANK_C: sel_we[2] = wr_fire;
      `ADPS_OFS_BANK_D: sel_we[3] = wr_fire;
      `ADPS_OFS_BANK_E: sel_we[4] = wr_fire;
      `ADPS_OFS_BANK_F: sel_we[5] = wr_fire;
      `ADPS_OFS_DIR_A: dir_we[0] = wr_fire;
      `ADPS_OFS_DIR_B: dir_we[1] = wr_fire;
      `ADPS_OFS_DIR_C: dir_we[2] = wr_fire;
      `ADPS_OFS_DIR_D: dir_we[3] = wr_fire;
      `ADPS_OFS_DIR_E: dir_we[4] = wr_fire;
      `ADPS_OFS_DIR_F: dir_we[5] = wr_fire;
      // level registers are read only; writes answer okay, no effect
      `ADPS_OFS_LVL_A, `ADPS_OFS_LVL_B, `ADPS_OFS_LVL_C,
      `ADPS_OFS_LVL_D, `ADPS_OFS_LVL_E, `ADPS_OFS_LVL_F: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response, one cycle after both halves are in
  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ADPS_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `ADPS_RESP_OKAY : `ADPS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // six banks, one instance each
  // the mask fixes which select bits exist; an absent bit is a
  // flip-flop held at zero, which synthesis folds away
  // readback per bank: select, direction, gated level
  wire [15:0] sel_a;
  wire [15:0] sel_b;
  wire [15:0] sel_c;
  wire [15:0] sel_d;
  wire [15:0] sel_e;
  wire [15:0] sel_f;
  wire [15:0] dir_a;
  wire [15:0] dir_b;
  wire [15:0] dir_c;
  wire [15:0] dir_d;
  wire [15:0] dir_e;
  wire [15:0] dir_f;
  wire [15:0] lvl_a;
  wire [15:0] lvl_b;
  wire [15:0] lvl_c;
  wire [15:0] lvl_d;
  wire [15:0] lvl_e;
  wire [15:0] lvl_f;

  // bank a: four select bits, gone in the small variant
  adps_bank #(
    .SEL_MASK(MASK_A)
  ) u_bank_a (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[0]),
    .dir_we(dir_we[0]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[15:0]),
    .analog_select(sel_a),
    .direction(dir_a),
    .pin_level(lvl_a),
    .analog_mode(analog_mode[15:0]),
    .output_en(output_en[15:0])
  );

  // bank b: every bit analog capable
  adps_bank #(
    .SEL_MASK(MASK_B)
  ) u_bank_b (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[1]),
    .dir_we(dir_we[1]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[31:16]),
    .analog_select(sel_b),
    .direction(dir_b),
    .pin_level(lvl_b),
    .analog_mode(analog_mode[31:16]),
    .output_en(output_en[31:16])
  );

  // bank c: three bits, bit 4 gone in the small variant
  adps_bank #(
    .SEL_MASK(MASK_C)
  ) u_bank_c (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[2]),
    .dir_we(dir_we[2]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[47:32]),
    .analog_select(sel_c),
    .direction(dir_c),
    .pin_level(lvl_c),
    .analog_mode(analog_mode[47:32]),
    .output_en(output_en[47:32])
  );

  // bank d: two bits
  adps_bank #(
    .SEL_MASK(MASK_D)
  ) u_bank_d (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[3]),
    .dir_we(dir_we[3]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[63:48]),
    .analog_select(sel_d),
    .direction(dir_d),
    .pin_level(lvl_d),
    .analog_mode(analog_mode[63:48]),
    .output_en(output_en[63:48])
  );

  // bank e: one bit, gone in the small variant
  adps_bank #(
    .SEL_MASK(MASK_E)
  ) u_bank_e (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[4]),
    .dir_we(dir_we[4]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[79:64]),
    .analog_select(sel_e),
    .direction(dir_e),
    .pin_level(lvl_e),
    .analog_mode(analog_mode[79:64]),
    .output_en(output_en[79:64])
  );

  // bank f: one bit
  adps_bank #(
    .SEL_MASK(MASK_F)
  ) u_bank_f (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel_we(sel_we[5]),
    .dir_we(dir_we[5]),
    .wdata(wr_data[15:0]),
    .wstrb(wr_strb[1:0]),
    .pin_in(pin_in[95:80]),
    .analog_select(sel_f),
    .direction(dir_f),
    .pin_level(lvl_f),
    .analog_mode(analog_mode[95:80]),
    .output_en(output_en[95:80])
  );

  // ==========================================================
  // read path: one read at a time, data registered
  // level words are sampled at the edge that takes the address,
  // not when rready comes, so a slow master sees the pad level
  // of its request and not a later one
  reg [15:0] rd_word;
  reg rd_hit;

  assign s_axi_arready = ~s_axi_rvalid;

  always @* begin
    rd_word = 16'h0000;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      `ADPS_OFS_BANK_A: rd_word = sel_a;
      `ADPS_OFS_BANK_B: rd_word = sel_b;
      `ADPS_OFS_BANK_C: rd_word = sel_c;
      `ADPS_OFS_BANK_D: rd_word = sel_d;
      `ADPS_OFS_BANK_E: rd_word = sel_e;
      `ADPS_OFS_BANK_F: rd_word = sel_f;
      `ADPS_OFS_DIR_A: rd_word = dir_a;
      `ADPS_OFS_DIR_B: rd_word = dir_b;
      `ADPS_OFS_DIR_C: rd_word = dir_c;
      `ADPS_OFS_DIR_D: rd_word = dir_d;
      `ADPS_OFS_DIR_E: rd_word = dir_e;
      `ADPS_OFS_DIR_F: rd_word = dir_f;
      `ADPS_OFS_LVL_A: rd_word = lvl_a;
      `ADPS_OFS_LVL_B: rd_word = lvl_b;
      `ADPS_OFS_LVL_C: rd_word = lvl_c;
      `ADPS_OFS_LVL_D: rd_word = lvl_d;
      `ADPS_OFS_LVL_E: rd_word = lvl_e;
      `ADPS_OFS_LVL_F: rd_word = lvl_f;
      default: rd_hit = 1'b0;
    endcase
  end

  // upper half always zero; unmapped reads give zero and slverr
  always @(posedge clk_sys) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ADPS_RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rd_word};
      s_axi_rresp <= rd_hit ? `ADPS_RESP_OKAY : `ADPS_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // adps_top

// >>> tb/adps_props.sv
// concurrent checks on the ports of the pin select block
`include "adps_consts.vh"
module adps_props #(
  parameter SMALL_PIN_COUNT = 0 // 1 means reduced variant
) (
  input wire clk_sys, // clock
  input wire rst, // sync reset
  input wire [7:0] s_axi_awaddr, // in
  input wire s_axi_awvalid, // in
  input wire s_axi_awready, // out
  input wire [31:0] s_axi_wdata, // in
  input wire [3:0] s_axi_wstrb, // in
  input wire s_axi_wvalid, // in
  input wire s_axi_wready, // out
  input wire [1:0] s_axi_bresp, // out
  input wire s_axi_bvalid, // out
  input wire s_axi_bready, // in
  input wire [7:0] s_axi_araddr, // in
  input wire s_axi_arvalid, // in
  input wire s_axi_arready, // out
  input wire [31:0] s_axi_rdata, // out
  input wire [1:0] s_axi_rresp, // out
  input wire s_axi_rvalid, // out
  input wire s_axi_rready, // in
  input wire [95:0] pin_in, // pads
  input wire [95:0] analog_mode, // out
  input wire [95:0] output_en // out
);
  // ==========================================================
  // expected select state right after reset, per variant
  localparam [95:0] RST_SEL = SMALL_PIN_COUNT ?
    {`ADPS_MASK_F, 16'h0000, `ADPS_MASK_D, `ADPS_MASK_C_SMALL,
     `ADPS_MASK_B, 16'h0000} :
    {`ADPS_MASK_F, `ADPS_MASK_E, `ADPS_MASK_D, `ADPS_MASK_C,
     `ADPS_MASK_B, `ADPS_MASK_A};
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========================================================
  // handshake steps
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
    else $error("write not answered one cycle later");
  a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered one cycle later");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before bready");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_analog_undriven: assert property ((output_en & analog_mode) == 96'h0)
    else $error("analog pin has digital driver on");
  a_reset_select: assert property ($fell(rst)
    |-> analog_mode == RST_SEL)
    else $error("select bits wrong after reset");
  a_reset_inputs: assert property ($fell(rst) |-> output_en == 96'h0)
    else $error("pin driven right after reset");
  a_mode_by_write: assert property (!$stable(analog_mode)
    |-> $rose(s_axi_bvalid))
    else $error("mode changed without a write");
endmodule // adps_props
bind adps_top adps_props #(.SMALL_PIN_COUNT(SMALL_PIN_COUNT)) i_props (
  .clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .pin_in, .analog_mode, .output_en);

// >>> tb/adps_top_bench.sv
// self-checking bench for the pin select block
`include "adps_consts.vh"
module adps_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, d;
  logic [3:0] s_axi_wstrb;
  logic [95:0] pin_in;
  logic [1:0] r;
  logic [15:0] msk [6];
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [95:0] analog_mode, output_en, small_mode;
  int n_errors, n_checks, cyc;
  adps_top i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .analog_mode,
    .output_en);
  // reduced variant beside it, fed the same bus; only its modes watched
  adps_top #(.SMALL_PIN_COUNT(1)) i_small (.clk_sys, .rst,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
    .s_axi_rready, .pin_in, .analog_mode(small_mode), .output_en());
  localparam logic [95:0] SMALL_SEL = {`ADPS_MASK_F, 16'h0000,
    `ADPS_MASK_D, `ADPS_MASK_C_SMALL, `ADPS_MASK_B, 16'h0000};
  task automatic close_out;
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input logic [95:0] g, input logic [95:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask
  // ==========================================================
  // bus tasks; ready is raised late so responses must hold
  task automatic wr(input logic [7:0] a, input logic [15:0] v,
      input logic [3:0] s);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, v};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) break;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge clk_sys);
      if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) break;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset;
    chk(analog_mode, {msk[5], msk[4], msk[3], msk[2], msk[1], msk[0]});
    chk(output_en, 96'h0);
    chk(small_mode, SMALL_SEL);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      chk(d, {16'h0000, msk[i]});
      rd(8'(32 + 4 * i));
      chk({r, d}, {2'b00, 32'h0000_FFFF});
    end
  endtask
  task automatic t_bits;
    for (int i = 0; i < 6; i++) begin
      wr(8'(4 * i), 16'h0000, 4'hF);
      rd(8'(4 * i));
      chk(d, 32'h0000_0000);
      chk(analog_mode[16 * i +: 16], 16'h0000);
      wr(8'(4 * i), 16'hFFFF, 4'hF);
      rd(8'(4 * i));
      chk(d, {16'h0000, msk[i]});
    end
    chk(small_mode, SMALL_SEL);
  endtask
  task automatic t_level;
    wr(`ADPS_OFS_BANK_B, 16'h00FF, 4'hF);
    wr(`ADPS_OFS_DIR_B, 16'h0F0F, 4'hF);
    rd(`ADPS_OFS_LVL_B);
    chk(d, {16'h0000, pin_in[31:16] & 16'hFF00});
    chk(output_en, {64'h0, 16'hF000, 16'h0000});
    wr(`ADPS_OFS_BANK_B, 16'h1234, 4'h2);
    rd(`ADPS_OFS_BANK_B);
    chk(d, 32'h0000_12FF);
  endtask
  task automatic t_bad;
    wr(8'h60, 16'h0000, 4'hF);
    chk(r, 2'b10);
    rd(8'h60);
    chk({r, d}, {2'b10, 32'h0000_0000});
  endtask
  // ==========================================================
  // clock, hang limit and main sequence
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    pin_in = 96'hA5C3_96F0_5A3C_0FF1_E1D2_C3B4;
    msk = '{`ADPS_MASK_A, `ADPS_MASK_B, `ADPS_MASK_C, `ADPS_MASK_D,
      `ADPS_MASK_E, `ADPS_MASK_F};
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    t_reset();
    t_bits();
    t_level();
    t_bad();
    close_out();
  end
endmodule // adps_top_bench
